// ---- core/pefo_map.svh ----
`ifndef PEFO_MAP_SVH
`define PEFO_MAP_SVH
// ==========================================================
// Register offsets
`define PEFO_OFS_PE_OUT 8'h00
`define PEFO_OFS_PE_DIR 8'h04
`define PEFO_OFS_PF_OUT 8'h08
`define PEFO_OFS_PF_DIR 8'h0c
`define PEFO_OFS_CFG 8'h10
`define PEFO_OFS_STATUS 8'h14
// ==========================================================
// Configuration fields and reset values
`define PEFO_CFG_PUD 0
`define PEFO_CFG_SCAN 1
`define PEFO_CFG_LEGACY 2
`define PEFO_PORT_RESET 8'h00
`define PEFO_PF_PU_RESET 8'hb0
`define PEFO_SCAN_PU_VALUE 4'hb
// ==========================================================
// Pin positions; port F sits above port E in 16-bit vectors
`define PEFO_PE_RX 0
`define PEFO_PE_TX 1
`define PEFO_PE_XCK 2
`define PEFO_PE_CMPA 3
`define PEFO_PE_CMPB 4
`define PEFO_PE_CMPC 5
`define PEFO_PE_TCLK 6
`define PEFO_PE_CAP 7
`define PEFO_PF_TCK 12
`define PEFO_PF_TMS 13
`define PEFO_PF_TDO 14
`define PEFO_PF_TDI 15
// ==========================================================
// Scan instruction codes
`define PEFO_IR_CAPTURE 4'h1
`define PEFO_IR_BYPASS 4'hf
`endif

// ---- core/pefo_pkg.sv ----
package pefo_pkg;
  // ========================================================
  // Scan controller states
  typedef enum logic [3:0] {
    st_test_reset, st_run_idle, st_reg_select, st_reg_capture,
    st_reg_shift, st_reg_exit1, st_reg_pause, st_reg_exit2,
    st_reg_update, st_instr_select, st_instr_capture,
    st_instr_shift, st_instr_exit1, st_instr_pause,
    st_instr_exit2, st_instr_update
  } pefo_tap_t;

  // ========================================================
  // Whole state of the override block
  typedef struct packed {
    logic [7:0] porte_out;
    logic [7:0] porte_dir;
    logic [7:0] portf_out;
    logic [7:0] portf_dir;
    logic global_pullup_off;
    logic scan_port_enable;
    logic legacy_mode;
    logic ack;
    logic waitreq;
    logic [31:0] readdata;
    pefo_tap_t tap;
    logic [3:0] instr;
    logic [3:0] instr_shift;
    logic [7:0] data_shift;
    logic tck_prev;
    logic tdo;
    logic tap_instr_shifting;
    logic tap_reg_shifting;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic [15:0] pull_on;
    logic [15:0] input_en;
    logic [15:0] sampled;
  } pefo_state_t;
endpackage

// ---- core/pefo_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Pad input synchroniser
// A bit changes only once the second and third stages agree,
// which also filters single-cycle glitches on the pads.
module pefo_pin_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pads and synchronised levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pefo_sync_t;

  pefo_sync_t st;
  pefo_sync_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st.s2[i] == st.s3[i])
        next_st.q[i] = st.s3[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign q = st.q;
endmodule
`default_nettype wire

// ---- core/pefo_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pefo_map.svh"
module pefo_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Port E pads
  input wire logic [7:0] pe_pin_in,
  output logic [7:0] pe_pin_out,
  output logic [7:0] pe_pin_oe,
  output logic [7:0] pe_pullup,
  output logic [7:0] pe_input_en,
  // Port F pads
  input wire logic [7:0] pf_pin_in,
  output logic [7:0] pf_pin_out,
  output logic [7:0] pf_pin_oe,
  output logic [7:0] pf_pullup,
  output logic [7:0] pf_input_en,
  // Serial channel 0
  input wire logic serial0_tx_enable,
  input wire logic serial0_rx_enable,
  input wire logic serial0_sync_select,
  input wire logic serial0_ext_clock_out,
  input wire logic serial0_tx_line,
  output logic serial0_rx_line,
  output logic serial0_ext_clock,
  // Serial programming
  input wire logic prog_download_active,
  input wire logic prog_serial_out,
  output logic prog_serial_in,
  // Timer three
  input wire logic timer_three_compare_a_en,
  input wire logic timer_three_compare_a_out,
  input wire logic timer_three_compare_b_en,
  input wire logic timer_three_compare_b_out,
  input wire logic timer_three_compare_c_en,
  input wire logic timer_three_compare_c_out,
  output logic timer_three_capture_in,
  output logic timer_three_clock_in,
  // External interrupts 4..7
  input wire logic [3:0] ext_irq_enable,
  output logic ext_irq_line_4,
  output logic ext_irq_line_5,
  output logic ext_irq_line_6,
  output logic ext_irq_line_7,
  // Analog paths
  output logic comparator_pos_in,
  output logic comparator_neg_in,
  output logic [7:0] converter_channel,
  // Scan status
  output logic scan_port_enable,
  output logic tap_instr_shifting,
  output logic tap_reg_shifting
);
  import pefo_pkg::*;

  pefo_state_t st;
  pefo_state_t next_st;
  logic [15:0] pad;

  pefo_pin_sync #(
    .W(16)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({pf_pin_in, pe_pin_in}),
    .q(pad)
  );

  // ========================================================
  // Scan controller transitions, taken on a test clock rise
  function automatic pefo_tap_t tap_next(input pefo_tap_t s, input logic tms);
    case (s)
      st_test_reset: tap_next = tms ? st_test_reset : st_run_idle;
      st_run_idle: tap_next = tms ? st_reg_select : st_run_idle;
      st_reg_select: tap_next = tms ? st_instr_select : st_reg_capture;
      st_reg_capture: tap_next = tms ? st_reg_exit1 : st_reg_shift;
      st_reg_shift: tap_next = tms ? st_reg_exit1 : st_reg_shift;
      st_reg_exit1: tap_next = tms ? st_reg_update : st_reg_pause;
      st_reg_pause: tap_next = tms ? st_reg_exit2 : st_reg_pause;
      st_reg_exit2: tap_next = tms ? st_reg_update : st_reg_shift;
      st_reg_update: tap_next = tms ? st_reg_select : st_run_idle;
      st_instr_select: tap_next = tms ? st_test_reset : st_instr_capture;
      st_instr_capture: tap_next = tms ? st_instr_exit1 : st_instr_shift;
      st_instr_shift: tap_next = tms ? st_instr_exit1 : st_instr_shift;
      st_instr_exit1: tap_next = tms ? st_instr_update : st_instr_pause;
      st_instr_pause: tap_next = tms ? st_instr_exit2 : st_instr_pause;
      st_instr_exit2: tap_next = tms ? st_instr_update : st_instr_shift;
      st_instr_update: tap_next = tms ? st_reg_select : st_run_idle;
      default: tap_next = st_test_reset;
    endcase
  endfunction

  always_comb
  begin
    logic req;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic [15:0] pu_oe;
    logic [15:0] pu_ov;
    logic [15:0] dd_oe;
    logic [15:0] dd_ov;
    logic [15:0] pv_oe;
    logic [15:0] pv_ov;
    logic [15:0] ie_oe;
    logic [15:0] ie_ov;
    logic [15:0] norm_dir;
    logic [15:0] norm_out;
    logic [15:0] norm_pu;
    req = 1'b0;
    tck_rise = 1'b0;
    tck_fall = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    pu_oe = '0;
    pu_ov = '0;
    dd_oe = '0;
    dd_ov = '0;
    pv_oe = '0;
    pv_ov = '0;
    ie_oe = '0;
    ie_ov = '0;
    norm_dir = '0;
    norm_out = '0;
    norm_pu = '0;
    next_st = st;

    // ======================================================
    // Register bus: one wait cycle, then the answer
    req = avs_read | avs_write;
    next_st.ack = req & ~st.ack;
    next_st.waitreq = ~(req & ~st.ack);
    if (avs_read && !st.ack)
    begin
      case (avs_address)
        `PEFO_OFS_PE_OUT: next_st.readdata = {24'h000000, st.porte_out};
        `PEFO_OFS_PE_DIR: next_st.readdata = {24'h000000, st.porte_dir};
        `PEFO_OFS_PF_OUT: next_st.readdata = {24'h000000, st.portf_out};
        `PEFO_OFS_PF_DIR: next_st.readdata = {24'h000000, st.portf_dir};
        `PEFO_OFS_CFG: next_st.readdata = {29'h00000000, st.legacy_mode,
                                          st.scan_port_enable, st.global_pullup_off};
        `PEFO_OFS_STATUS: next_st.readdata = {8'h00, st.instr, st.tap, st.sampled};
        default: next_st.readdata = 32'h00000000;
      endcase
    end
    if (avs_write && st.ack && avs_byteenable[0])
    begin
      case (avs_address)
        `PEFO_OFS_PE_OUT: next_st.porte_out = avs_writedata[7:0];
        `PEFO_OFS_PE_DIR: next_st.porte_dir = avs_writedata[7:0];
        `PEFO_OFS_PF_OUT: next_st.portf_out = avs_writedata[7:0];
        `PEFO_OFS_PF_DIR: next_st.portf_dir = avs_writedata[7:0];
        `PEFO_OFS_CFG:
        begin
          next_st.global_pullup_off = avs_writedata[`PEFO_CFG_PUD];
          next_st.scan_port_enable = avs_writedata[`PEFO_CFG_SCAN];
          next_st.legacy_mode = avs_writedata[`PEFO_CFG_LEGACY];
        end
        default: next_st.readdata = st.readdata;
      endcase
    end

    // ======================================================
    // Port E overrides
    if (prog_download_active)
    begin
      dd_oe[`PEFO_PE_RX] = 1'b1;
      dd_ov[`PEFO_PE_RX] = 1'b0;
    end
    else if (serial0_rx_enable)
    begin
      pu_oe[`PEFO_PE_RX] = 1'b1;
      pu_ov[`PEFO_PE_RX] = st.porte_out[`PEFO_PE_RX] & ~st.global_pullup_off;
      dd_oe[`PEFO_PE_RX] = 1'b1;
      dd_ov[`PEFO_PE_RX] = 1'b0;
    end
    // Programming outranks the transmitter; both want the same pin.
    if (prog_download_active || serial0_tx_enable)
    begin
      pu_oe[`PEFO_PE_TX] = 1'b1;
      dd_oe[`PEFO_PE_TX] = 1'b1;
      dd_ov[`PEFO_PE_TX] = 1'b1;
      pv_oe[`PEFO_PE_TX] = 1'b1;
      pv_ov[`PEFO_PE_TX] = prog_download_active ? prog_serial_out : serial0_tx_line;
    end
    pv_oe[`PEFO_PE_XCK] = serial0_sync_select;
    pv_ov[`PEFO_PE_XCK] = serial0_ext_clock_out;
    pv_oe[`PEFO_PE_CMPA] = timer_three_compare_a_en;
    pv_ov[`PEFO_PE_CMPA] = timer_three_compare_a_out;
    pv_oe[`PEFO_PE_CMPB] = timer_three_compare_b_en;
    pv_ov[`PEFO_PE_CMPB] = timer_three_compare_b_out;
    pv_oe[`PEFO_PE_CMPC] = timer_three_compare_c_en;
    pv_ov[`PEFO_PE_CMPC] = timer_three_compare_c_out;
    ie_oe[7:4] = ext_irq_enable;
    ie_ov[7:4] = 4'hf;

    // ======================================================
    // Port F overrides; the lower four never take any
    if (st.scan_port_enable)
    begin
      pu_oe[15:12] = 4'hf;
      pu_ov[15:12] = `PEFO_SCAN_PU_VALUE;
      dd_oe[15:12] = 4'hf;
      dd_ov[`PEFO_PF_TDO] = st.tap_instr_shifting | st.tap_reg_shifting;
      pv_oe[`PEFO_PF_TDO] = 1'b1;
      pv_ov[`PEFO_PF_TDO] = st.tdo;
      ie_oe[15:12] = 4'hf;
      ie_ov[15:12] = 4'h0;
    end

    // ======================================================
    // Combine overrides with the port registers
    // Legacy mode masks the register, so port F stays input-only except
    // for the test output pin, which the scan override still drives while shifting.
    norm_dir = {st.portf_dir & ~{8{st.legacy_mode}}, st.porte_dir};
    norm_out = {st.portf_out, st.porte_out};
    norm_pu = norm_out & ~norm_dir & ~{16{st.global_pullup_off}};
    for (int i = 0; i < 16; i++)
    begin
      next_st.pull_on[i] = pu_oe[i] ? pu_ov[i] : norm_pu[i];
      next_st.pin_oe[i] = dd_oe[i] ? dd_ov[i] : norm_dir[i];
      next_st.pin_out[i] = pv_oe[i] ? pv_ov[i] : norm_out[i];
      next_st.input_en[i] = ie_oe[i] ? ie_ov[i] : 1'b1;
    end
    next_st.sampled = pad;

    // ======================================================
    // Scan controller, stepped by the synchronised test clock
    tms = pad[`PEFO_PF_TMS];
    tdi = pad[`PEFO_PF_TDI];
    next_st.tck_prev = pad[`PEFO_PF_TCK];
    tck_rise = pad[`PEFO_PF_TCK] & ~st.tck_prev;
    tck_fall = ~pad[`PEFO_PF_TCK] & st.tck_prev;
    if (!st.scan_port_enable)
    begin
      next_st.tap = st_test_reset;
      next_st.instr = `PEFO_IR_BYPASS;
    end
    else if (tck_rise)
    begin
      next_st.tap = tap_next(st.tap, tms);
      case (st.tap)
        st_test_reset: next_st.instr = `PEFO_IR_BYPASS;
        st_instr_capture: next_st.instr_shift = `PEFO_IR_CAPTURE;
        st_instr_shift: next_st.instr_shift = {tdi, st.instr_shift[3:1]};
        st_instr_update: next_st.instr = st.instr_shift;
        st_reg_capture: next_st.data_shift = (st.instr == `PEFO_IR_BYPASS) ? 8'h00 : pad[7:0];
        st_reg_shift:
        begin
          if (st.instr == `PEFO_IR_BYPASS)
            next_st.data_shift[0] = tdi;
          else
            next_st.data_shift = {tdi, st.data_shift[7:1]};
        end
        default: next_st.instr = st.instr;
      endcase
    end
    // Output data changes on the falling test clock edge.
    if (tck_fall)
      next_st.tdo = (st.tap == st_instr_shift) ? st.instr_shift[0] : st.data_shift[0];
    next_st.tap_instr_shifting = (next_st.tap == st_instr_shift);
    next_st.tap_reg_shifting = (next_st.tap == st_reg_shift);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '0;
      st.waitreq <= 1'b1;
      st.scan_port_enable <= 1'b1;
      st.pull_on <= {`PEFO_PF_PU_RESET, `PEFO_PORT_RESET};
      st.input_en <= 16'h0fff;
      st.instr <= `PEFO_IR_BYPASS;
      st.tap <= st_test_reset;
    end
    else
      st <= next_st;
  end

  // ========================================================
  // Outputs, each straight from the state register
  assign avs_readdata = st.readdata;
  assign avs_waitrequest = st.waitreq;
  assign pe_pin_out = st.pin_out[7:0];
  assign pe_pin_oe = st.pin_oe[7:0];
  assign pe_pullup = st.pull_on[7:0];
  assign pe_input_en = st.input_en[7:0];
  assign pf_pin_out = st.pin_out[15:8];
  assign pf_pin_oe = st.pin_oe[15:8];
  assign pf_pullup = st.pull_on[15:8];
  assign pf_input_en = st.input_en[15:8];
  assign serial0_rx_line = st.sampled[`PEFO_PE_RX];
  assign prog_serial_in = st.sampled[`PEFO_PE_RX];
  assign serial0_ext_clock = st.sampled[`PEFO_PE_XCK];
  assign comparator_pos_in = st.sampled[`PEFO_PE_XCK];
  assign comparator_neg_in = st.sampled[`PEFO_PE_CMPA];
  assign timer_three_clock_in = st.sampled[`PEFO_PE_TCLK];
  assign timer_three_capture_in = st.sampled[`PEFO_PE_CAP];
  assign ext_irq_line_4 = st.sampled[4];
  assign ext_irq_line_5 = st.sampled[5];
  assign ext_irq_line_6 = st.sampled[6];
  assign ext_irq_line_7 = st.sampled[7];
  assign converter_channel = st.sampled[15:8];
  assign scan_port_enable = st.scan_port_enable;
  assign tap_instr_shifting = st.tap_instr_shifting;
  assign tap_reg_shifting = st.tap_reg_shifting;

  // ========================================================
  // Assertions
  property p_rx_input;
    @(posedge clk) disable iff (rst)
    serial0_rx_enable |=> !pe_pin_oe[0];
  endproperty
  a_rx_input: assert property (p_rx_input) else $error("rx pin not input");

  property p_rx_pullup;
    @(posedge clk) disable iff (rst)
    (serial0_rx_enable && !prog_download_active) |=>
      pe_pullup[0] == ($past(st.porte_out[0]) && !$past(st.global_pullup_off));
  endproperty
  a_rx_pullup: assert property (p_rx_pullup) else $error("rx pull-up wrong");

  property p_tx_drive;
    @(posedge clk) disable iff (rst)
    (serial0_tx_enable && !prog_download_active) |=>
      pe_pin_oe[1] && !pe_pullup[1] && pe_pin_out[1] == $past(serial0_tx_line);
  endproperty
  a_tx_drive: assert property (p_tx_drive) else $error("tx pin wrong");

  property p_prog_io;
    @(posedge clk) disable iff (rst)
    prog_download_active |=> pe_pin_oe[1] && !pe_pin_oe[0] && pe_pin_out[1] == $past(prog_serial_out);
  endproperty
  a_prog_io: assert property (p_prog_io) else $error("programming pins wrong");

  property p_xck;
    @(posedge clk) disable iff (rst)
    serial0_sync_select |=> pe_pin_out[2] == $past(serial0_ext_clock_out) && pe_pin_oe[2] == $past(st.porte_dir[2]);
  endproperty
  a_xck: assert property (p_xck) else $error("clock pin wrong");

  property p_cmp_c;
    @(posedge clk) disable iff (rst)
    timer_three_compare_c_en |=> pe_pin_out[5] == $past(timer_three_compare_c_out);
  endproperty
  a_cmp_c: assert property (p_cmp_c) else $error("compare output wrong");

  property p_comparator;
    @(posedge clk) disable iff (rst)
    !rst |=> comparator_pos_in == $past(pad[2]) && comparator_neg_in == $past(pad[3]);
  endproperty
  a_comparator: assert property (p_comparator) else $error("comparator path wrong");

  property p_scan_pins;
    @(posedge clk) disable iff (rst)
    st.scan_port_enable |=> pf_pullup[7:4] == 4'hb && pf_input_en[7:4] == 4'h0 && !pf_pin_oe[7]
      && !pf_pin_oe[5] && !pf_pin_oe[4];
  endproperty
  a_scan_pins: assert property (p_scan_pins) else $error("scan pins wrong");

  property p_tdo_tristate;
    @(posedge clk) disable iff (rst)
    (st.scan_port_enable && !tap_instr_shifting && !tap_reg_shifting) |=> !pf_pin_oe[6];
  endproperty
  a_tdo_tristate: assert property (p_tdo_tristate) else $error("test output driven");

  property p_tap_steps;
    @(posedge clk) disable iff (rst)
    (st.scan_port_enable && !(pad[12] && !st.tck_prev)) |=> $stable(st.tap);
  endproperty
  a_tap_steps: assert property (p_tap_steps) else $error("scan state moved without clock");

  property p_legacy;
    @(posedge clk) disable iff (rst)
    st.legacy_mode |=> pf_pin_oe[3:0] == 4'h0 && pf_input_en[3:0] == 4'hf;
  endproperty
  a_legacy: assert property (p_legacy) else $error("port F not input-only");

  property p_bus_answer;
    @(posedge clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  c_rx: cover property (@(posedge clk) disable iff (rst) serial0_rx_enable ##1 !pe_pin_oe[0]);
  c_ir_shift: cover property (@(posedge clk) disable iff (rst) tap_instr_shifting ##1 pf_pin_oe[6]);
  c_dr_shift: cover property (@(posedge clk) disable iff (rst) tap_reg_shifting);
  c_write: cover property (@(posedge clk) disable iff (rst) avs_write && !avs_waitrequest);
endmodule
`default_nettype wire

// ---- test/pefo_pad_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Board pads around the override block
// An undriven pad without a pull-up flips every cycle, so a stale level never passes for a real one.
module pefo_pad_model (
  // Clock
  input wire logic clk,
  // Device side
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pull_on,
  // Board side
  input wire logic [15:0] ext_en,
  input wire logic [15:0] ext_val,
  output logic [15:0] pad
);
  logic [15:0] float_v = 16'h0000;
  always @(posedge clk)
  begin
    float_v <= ~float_v;
  end
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (pin_oe[i])
        pad[i] = pin_out[i];
      else if (ext_en[i])
        pad[i] = ext_val[i];
      else
        pad[i] = pull_on[i] ? 1'b1 : float_v[i];
    end
  end
endmodule
`default_nettype wire

// ---- test/pefo_mux_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pefo_map.svh"
// ==========================================================
// Bench for the port E and F override block
module pefo_mux_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest;
  logic [7:0] pe_out, pe_oe, pe_pu, pe_ie, pf_out, pf_oe, pf_pu, pf_ie, conv;
  logic [15:0] pad, ext_en = 16'h0000, ext_val = 16'h0000;
  logic tx_en = 0, rx_en = 0, sync_sel = 0, xck_out = 0, tx_line = 0, prog_act = 0, prog_out = 0;
  logic [2:0] cmp_en = 3'h0, cmp_out = 3'h0;
  logic [3:0] irq_en = 4'h0, irq;
  logic rx_line, xck_in, prog_in, cap_in, tclk_in, cpos, cneg, scan_en, ir_sh, dr_sh;
  int n_errors = 0, checked = 0;

  always #5 clk = ~clk;

  pefo_mux dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(4'hf), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pe_pin_in(pad[7:0]), .pe_pin_out(pe_out), .pe_pin_oe(pe_oe),
    .pe_pullup(pe_pu), .pe_input_en(pe_ie), .pf_pin_in(pad[15:8]), .pf_pin_out(pf_out), .pf_pin_oe(pf_oe),
    .pf_pullup(pf_pu), .pf_input_en(pf_ie), .serial0_tx_enable(tx_en), .serial0_rx_enable(rx_en),
    .serial0_sync_select(sync_sel), .serial0_ext_clock_out(xck_out), .serial0_tx_line(tx_line),
    .serial0_rx_line(rx_line), .serial0_ext_clock(xck_in), .prog_download_active(prog_act),
    .prog_serial_out(prog_out), .prog_serial_in(prog_in), .timer_three_compare_a_en(cmp_en[0]),
    .timer_three_compare_a_out(cmp_out[0]), .timer_three_compare_b_en(cmp_en[1]),
    .timer_three_compare_b_out(cmp_out[1]), .timer_three_compare_c_en(cmp_en[2]),
    .timer_three_compare_c_out(cmp_out[2]), .timer_three_capture_in(cap_in), .timer_three_clock_in(tclk_in),
    .ext_irq_enable(irq_en), .ext_irq_line_4(irq[0]), .ext_irq_line_5(irq[1]), .ext_irq_line_6(irq[2]),
    .ext_irq_line_7(irq[3]), .comparator_pos_in(cpos), .comparator_neg_in(cneg), .converter_channel(conv),
    .scan_port_enable(scan_en), .tap_instr_shifting(ir_sh), .tap_reg_shifting(dr_sh));

  pefo_pad_model pads (.clk(clk), .pin_out({pf_out, pe_out}), .pin_oe({pf_oe, pe_oe}),
    .pull_on({pf_pu, pe_pu}), .ext_en(ext_en), .ext_val(ext_val), .pad(pad));

  // ==========================================================
  // Shared tasks
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Pad paths take five edges; control overrides one.
  // Outputs are read at a rising edge, before that edge's own updates land.
  task settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // The request stands until waitrequest is sampled low; only the watchdog ends a hung wait.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Half period of six clocks keeps the test clock well inside what the synchroniser follows.
  task tck(input logic tms, input logic tdi);
    ext_val[13] <= tms;
    ext_val[15] <= tdi;
    ext_val[12] <= 1'b0;
    repeat (6) @(posedge clk);
    ext_val[12] <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    chk("pf_pullup", pf_pu, 8'hb0);
    chk("pe_input_en", pe_ie, 8'hff);
    chk("pf_input_en", pf_ie, 8'h0f);
    chk("pf_oe", pf_oe, 8'h00);
    chk("scan_en", scan_en, 1'b1);
    rst <= 1'b1;
    settle(3);
    chk("pf_pullup in reset", pf_pu, 8'hb0);
    @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, `PEFO_OFS_PE_DIR, 32'ha5);
    bus(1'b0, `PEFO_OFS_PE_DIR, 32'h0);
    chk("pe_dir", q, 32'ha5);
    chk("pe_oe", pe_oe, 8'ha5);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, `PEFO_OFS_PE_OUT, 32'h01);
    bus(1'b1, `PEFO_OFS_PE_DIR, 32'h01);
    $display("reset and bus done");
  endtask

  task t_rx;
    rx_en <= 1'b1;
    ext_en[0] <= 1'b1;
    settle(2);
    chk("rx oe0", pe_oe[0], 1'b0);
    chk("rx pullup0", pe_pu[0], 1'b1);
    settle(8);
    chk("rx_line low", rx_line, 1'b0);
    ext_val[0] <= 1'b1;
    settle(8);
    chk("rx_line high", rx_line, 1'b1);
    chk("prog_in", prog_in, 1'b1);
    bus(1'b1, `PEFO_OFS_CFG, 32'h03);
    settle(2);
    chk("rx pullup off", pe_pu[0], 1'b0);
    bus(1'b1, `PEFO_OFS_CFG, 32'h02);
    rx_en <= 1'b0;
    ext_en[0] <= 1'b0;
    $display("receiver done");
  endtask

  task t_tx;
    bus(1'b1, `PEFO_OFS_PE_OUT, 32'h02);
    bus(1'b1, `PEFO_OFS_PE_DIR, 32'h00);
    tx_en <= 1'b1;
    tx_line <= 1'b1;
    settle(2);
    chk("tx oe1 out1 pu1", {pe_oe[1], pe_out[1], pe_pu[1]}, 3'b110);
    tx_line <= 1'b0;
    prog_act <= 1'b1;
    prog_out <= 1'b1;
    settle(2);
    chk("prog out1", {pe_oe[1], pe_out[1]}, 2'b11);
    prog_act <= 1'b0;
    settle(2);
    chk("tx out1", pe_out[1], 1'b0);
    tx_en <= 1'b0;
    sync_sel <= 1'b1;
    xck_out <= 1'b1;
    bus(1'b1, `PEFO_OFS_PE_DIR, 32'h04);
    settle(2);
    chk("xck out", {pe_oe[2], pe_out[2]}, 2'b11);
    sync_sel <= 1'b0;
    settle(2);
    chk("xck off", pe_out[2], 1'b0);
    bus(1'b1, `PEFO_OFS_PE_DIR, 32'h00);
    ext_en[3:2] <= 2'b11;
    ext_val[3:2] <= 2'b01;
    settle(8);
    chk("xck in", {xck_in, cpos, cneg}, 3'b110);
    $display("transmit and clock done");
  endtask

  task t_upper;
    cmp_en <= 3'b111;
    cmp_out <= 3'b011;
    irq_en <= 4'hf;
    ext_en[7:4] <= 4'hf;
    ext_val[7:4] <= 4'ha;
    settle(8);
    chk("compare outs", pe_out[5:3], 3'b011);
    chk("irq lines", {irq, cap_in, tclk_in}, 6'b101010);
    chk("irq input_en", pe_ie[7:4], 4'hf);
    bus(1'b1, `PEFO_OFS_PF_DIR, 32'h0f);
    settle(2);
    chk("pf oe", pf_oe[3:0], 4'hf);
    // Legacy mode makes port F input-only for the rest of this task.
    bus(1'b1, `PEFO_OFS_CFG, 32'h06);
    ext_en[11:8] <= 4'hf;
    ext_val[11:8] <= 4'h9;
    settle(8);
    chk("legacy oe", pf_oe[3:0], 4'h0);
    chk("channels", conv[3:0], 4'h9);
    $display("upper bits and legacy done");
  endtask

  task t_scan;
    bus(1'b1, `PEFO_OFS_CFG, 32'h02);
    bus(1'b1, `PEFO_OFS_PF_DIR, 32'hf0);
    ext_en[15:12] <= 4'hb;
    settle(2);
    chk("scan oe", pf_oe[7:4], 4'h0);
    chk("scan ie", pf_ie[7:4], 4'h0);
    tck(0, 0);
    tck(1, 0);
    tck(1, 0);
    tck(0, 0);
    tck(0, 0);
    settle(8);
    chk("tap_instr_shifting", {ir_sh, dr_sh, pf_oe[6]}, 3'b101);
    tck(0, 1);
    // The fall before this rise put out the lowest captured instruction bit.
    chk("tdo", pf_out[6], 1'b1);
    tck(0, 0);
    tck(0, 1);
    tck(1, 0);
    tck(1, 0);
    tck(0, 0);
    settle(8);
    chk("idle tdo", {ir_sh, pf_oe[6]}, 2'b00);
    bus(1'b0, `PEFO_OFS_STATUS, 32'h0);
    chk("instr", q[23:20], 4'h5);
    bus(1'b1, `PEFO_OFS_CFG, 32'h00);
    settle(2);
    chk("scan off", {pf_pu[7:4], pf_ie, scan_en}, 13'h01fe);
    $display("scan done");
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Sequence and watchdog
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    t_reset;
    t_rx;
    t_tx;
    t_upper;
    t_scan;
    wrap_up;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
